/* File: rtl/kwu_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "kwu_defines.svh"
module kwu_top (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [3:0]  interrupt_inputs_0_to_3,
   input  wire logic [1:0]  power_mode,
   output logic             key_irq,
   output logic             core_wake,
   output logic             bus_irq,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   kwu_reg_if rif ();

   logic        rst_s1_ff;
   logic        rst_s2_ff;
   logic        rst_n;
   logic        rst_req_n;
   logic        deep_stop;
   logic [3:0]  pin_s1_ff;
   logic [3:0]  pin_s2_ff;
   logic [7:0]  pe_ff;
   logic [7:0]  es_ff;
   logic        mode_ff;
   logic        reqen_ff;
   logic [1:0]  ist_ff;
   logic [1:0]  imsk_ff;
   logic [5:0]  aw_ff;
   logic        aw_have_ff;
   logic [31:0] wd_ff;
   logic [3:0]  ws_ff;
   logic        w_have_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        wr_go;
   logic        wr_lane0;
   logic [3:0]  async_hit;
   logic        wake_ev;

   // Unit is held in reset through the deeper stop modes
   assign deep_stop = (power_mode == kwu_pkg::KWU_STOPD);

   // Deep stop asserts reset at once; its release still passes both flops
   assign rst_req_n = arst_n & ~deep_stop;

   always_ff @(posedge clock or negedge rst_req_n) begin
      if (!rst_req_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_n = rst_s2_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
      end else begin
         pin_s1_ff <= interrupt_inputs_0_to_3;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   kwu_detect u_detect (
      .clock     (clock),
      .rst_n     (rst_n),
      .pins_sync (pin_s2_ff),
      .rif       (rif)
   );

   assign rif.pin_enable = pe_ff & `KWU_PIN_MASK;
   assign rif.pin_polarity = es_ff & `KWU_PIN_MASK;
   assign rif.detect_mode = mode_ff;

   // Same behaviour in run, wait and debug halt: nothing here stops
   assign key_irq = rif.detect_flag & reqen_ff;

   // Clockless path for stop3: raw enabled pin at its asserted level
   assign async_hit = rif.pin_enable[3:0]
                    & ~(interrupt_inputs_0_to_3 ^ rif.pin_polarity[3:0]);
   assign core_wake = reqen_ff & (rif.detect_flag
                    | ((power_mode == kwu_pkg::KWU_STOP3) & |async_hit));
   assign wake_ev = rif.detect_pulse & reqen_ff;

   // AXI write path
   assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_have_ff & ~bvalid_ff;
   assign wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
   assign wr_lane0 = wr_go & ws_ff[0];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_ff <= 6'h00;
         wd_ff <= 32'h0000_0000;
         ws_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wd_ff <= s_axi_wdata;
            ws_ff <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `KWU_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         if (aw_ff == `KWU_OFS_SC || aw_ff == `KWU_OFS_PE ||
             aw_ff == `KWU_OFS_ES || aw_ff == `KWU_OFS_IST ||
             aw_ff == `KWU_OFS_IMSK) begin
            bresp_ff <= `KWU_RESP_OKAY;
         end else begin
            bresp_ff <= `KWU_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= 1'b0;
         reqen_ff <= 1'b0;
         pe_ff <= 8'h00;
         es_ff <= 8'h00;
         imsk_ff <= 2'h0;
      end else if (wr_lane0) begin
         if (aw_ff == `KWU_OFS_SC) begin
            mode_ff <= wd_ff[`KWU_SC_MODE];
            reqen_ff <= wd_ff[`KWU_SC_REQEN];
         end else if (aw_ff == `KWU_OFS_PE) begin
            pe_ff <= wd_ff[7:0];
         end else if (aw_ff == `KWU_OFS_ES) begin
            es_ff <= wd_ff[7:0];
         end else if (aw_ff == `KWU_OFS_IMSK) begin
            imsk_ff <= wd_ff[1:0];
         end
      end
   end

   // Acknowledge strobe only; the flag bit itself is not writable
   assign rif.ack_pulse = wr_lane0 && aw_ff == `KWU_OFS_SC
                        && wd_ff[`KWU_SC_ACK];

   // Sticky status: a new event wins over a write-one clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ist_ff <= 2'h0;
      end else begin
         if (rif.detect_pulse) begin
            ist_ff[`KWU_IST_DETECT] <= 1'b1;
         end else if (wr_lane0 && aw_ff == `KWU_OFS_IST
                      && wd_ff[`KWU_IST_DETECT]) begin
            ist_ff[`KWU_IST_DETECT] <= 1'b0;
         end
         if (wake_ev) begin
            ist_ff[`KWU_IST_WAKE] <= 1'b1;
         end else if (wr_lane0 && aw_ff == `KWU_OFS_IST
                      && wd_ff[`KWU_IST_WAKE]) begin
            ist_ff[`KWU_IST_WAKE] <= 1'b0;
         end
      end
   end
   assign bus_irq = |(ist_ff & imsk_ff);

   // AXI read path
   assign s_axi_arready = ~rvalid_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `KWU_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= `KWU_RESP_OKAY;
         if (s_axi_araddr == `KWU_OFS_SC) begin
            // Acknowledge and upper bits read zero
            rdata_ff <= {28'h0000000, rif.detect_flag, 1'b0,
                         reqen_ff, mode_ff};
         end else if (s_axi_araddr == `KWU_OFS_PE) begin
            rdata_ff <= {24'h000000, pe_ff};
         end else if (s_axi_araddr == `KWU_OFS_ES) begin
            rdata_ff <= {24'h000000, es_ff};
         end else if (s_axi_araddr == `KWU_OFS_IST) begin
            rdata_ff <= {30'h00000000, ist_ff};
         end else if (s_axi_araddr == `KWU_OFS_IMSK) begin
            rdata_ff <= {30'h00000000, imsk_ff};
         end else begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `KWU_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

/* File: rtl/kwu_defines.svh */
// Functional notes
// - The unit has eight pin positions, of which only pins 0 to 3 exist.
// - A pin enable bit of 1 makes its pin an interrupt source; 0 ignores it.
// - A polarity bit of 0 selects falling edge and low level, 1 rising and high.
// - Mode bit 0 selects edge-only detection (0) or edge plus level (1).
// - Request enable bit 1 gates the set flag onto the interrupt request.
// - Flag bit 3 reads 1 after a detection, and writes to bit 3 never change it.
// - Acknowledge bit 2 is a write-one strobe that helps clear the flag and reads 0.
// - Bits 7 to 4 of the status/control register read as zero.
// - In wait mode the unit keeps running and can wake the core.
// - In the shallowest stop mode pin activity is seen without the clock and wakes the core.
// - In the two deeper stop modes the unit is off and wakes up in its reset state.
// - In background debug mode the unit works exactly as in run mode.
// - An edge is the deasserted level in one cycle followed by the asserted level in the next.
// - After an edge, all enabled pins must return deasserted before a new edge is accepted.
// - Writing 1 to acknowledge clears the flag; in edge-and-level mode only with all pins idle.
// - In edge-and-level mode the flag stays set if any enabled pin is still asserted.
`ifndef KWU_DEFINES_SVH
`define KWU_DEFINES_SVH
`define KWU_ADDR_W        6
`define KWU_OFS_SC        6'h00
`define KWU_OFS_PE        6'h04
`define KWU_OFS_ES        6'h08
`define KWU_OFS_IST       6'h0C
`define KWU_OFS_IMSK      6'h10
`define KWU_SC_MODE       0
`define KWU_SC_REQEN      1
`define KWU_SC_ACK        2
`define KWU_SC_FLAG       3
`define KWU_PIN_MASK      8'h0F
`define KWU_NUM_PINS      4
`define KWU_RESP_OKAY     2'h0
`define KWU_RESP_SLVERR   2'h2
`define KWU_IST_DETECT    0
`define KWU_IST_WAKE      1
`endif

/* File: rtl/kwu_pkg.sv */
package kwu_pkg;
   typedef enum logic [1:0] {
      KWU_RUN   = 2'h0,
      KWU_WAIT  = 2'h1,
      KWU_STOP3 = 2'h2,
      KWU_STOPD = 2'h3
   } kwu_pmode_t;
endpackage

/* File: rtl/kwu_reg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface kwu_reg_if;
   logic [7:0] pin_enable;
   logic [7:0] pin_polarity;
   logic       detect_mode;
   logic       ack_pulse;
   logic       detect_pulse;
   logic       detect_flag;
   modport regs (output pin_enable, output pin_polarity, output detect_mode,
                 output ack_pulse, input detect_pulse, input detect_flag);
   modport core (input pin_enable, input pin_polarity, input detect_mode,
                 input ack_pulse, output detect_pulse, output detect_flag);
endinterface
`default_nettype wire

/* File: rtl/kwu_detect.sv */
`timescale 1ns/10ps
`default_nettype none
`include "kwu_defines.svh"
module kwu_detect (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [3:0] pins_sync,
   kwu_reg_if.core         rif
);
   logic [3:0] en;
   logic [3:0] asserted;
   logic [3:0] prev_ff;
   logic       armed_ff;
   logic       flag_ff;
   logic       any_asserted;
   logic       edge_hit;
   logic       level_hit;
   logic       set_ev;

   assign en = rif.pin_enable[3:0];
   assign asserted = en & ~(pins_sync ^ rif.pin_polarity[3:0]);
   assign any_asserted = |asserted;
   // Previous cycle deasserted and now asserted
   assign edge_hit = armed_ff & |(asserted & ~prev_ff);
   assign level_hit = rif.detect_mode & any_asserted;
   assign set_ev = edge_hit | level_hit;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= 4'h0;
      end else begin
         prev_ff <= asserted;
      end
   end

   // Re-arm only when every enabled pin is idle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff <= 1'b0;
      end else if (!any_asserted) begin
         armed_ff <= 1'b1;
      end else if (edge_hit) begin
         armed_ff <= 1'b0;
      end
   end

   // A detection in the acknowledge cycle wins over the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else if (set_ev) begin
         flag_ff <= 1'b1;
      end else if (rif.ack_pulse) begin
         flag_ff <= 1'b0;
      end
   end

   assign rif.detect_flag = flag_ff;
   assign rif.detect_pulse = set_ev & ~flag_ff;
endmodule
`default_nettype wire

/* File: sim/kwu_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "kwu_defines.svh"
module kwu_properties (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [1:0]  power_mode,
   input wire logic        key_irq,
   input wire logic        core_wake,
   input wire logic        bus_irq,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [5:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   irq_needs_wake_a: assert property (key_irq |-> core_wake)
      else $error("interrupt without wake");
   wake_tracks_irq_a: assert property (power_mode != 2'h2 |-> core_wake == key_irq)
      else $error("wake differs from interrupt outside stop3");
   deep_stop_quiet_a: assert property (power_mode == 2'h3 |-> !key_irq && !core_wake && !bus_irq)
      else $error("outputs active in deep stop");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while response pending");
   sc_zero_bits_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `KWU_OFS_SC |=> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[2])
      else $error("status control reserved or ack bit reads one");
   slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   status_sticky_a: assert property ($fell(key_irq) || $fell(bus_irq) |-> $rose(s_axi_bvalid) || power_mode == 2'h3)
      else $error("interrupt dropped without a register write");
   cover property (key_irq && bus_irq);
   cover property (power_mode == 2'h2 && core_wake);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind kwu_top kwu_properties u_props (.clock, .arst_n, .power_mode, .key_irq,
   .core_wake, .bus_irq, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* File: sim/kwu_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none
module kwu_pins_model (
   input  wire logic  clock,
   output logic [3:0] pins
);
   initial pins = 4'hF;
   // Switches move just after a bus edge, so no change straddles sampling
   task automatic set(input logic [3:0] v);
      @(posedge clock);
      pins <= v;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "kwu_defines.svh"
module tb_top;
   localparam logic [5:0] sc = `KWU_OFS_SC, pe = `KWU_OFS_PE, es = `KWU_OFS_ES;
   localparam logic [5:0] ist = `KWU_OFS_IST, imsk = `KWU_OFS_IMSK;
   logic        clock = 1'b0;
   logic        arst_n;
   logic [1:0]  power_mode;
   logic [3:0]  pins;
   logic        key_irq, core_wake, bus_irq;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          error_cnt = 0, total_checks = 0;
   always #12.5 clock = ~clock;
   kwu_top uut (.clock, .arst_n, .interrupt_inputs_0_to_3(pins), .power_mode,
      .key_irq, .core_wake, .bus_irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   kwu_pins_model pm (.clock, .pins);
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         $display("mismatch %s exp %h got %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Response ready is raised late on purpose to exercise the stall path
   task automatic wr(input logic [5:0] a, input logic [7:0] d,
                     input logic [1:0] r = 2'h0, input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && s_axi_awready !== 1'b1 ||
                  s_axi_wvalid && s_axi_wready !== 1'b1) && n < 50);
      while (s_axi_bvalid !== 1'b1 && n < 50) begin
         @(posedge clock);
         n++;
      end
      s_axi_bready <= 1'b1;
      @(posedge clock);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
      if (n >= 50) chk("wr_timeout", 0, 1);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e,
                      input logic [1:0] r = 2'h0);
      int n;
      n = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 50);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b1;
      @(posedge clock);
      s_axi_rready <= 1'b0;
      chk("rdata", {24'h0, e}, s_axi_rdata);
      chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
      if (n >= 50) chk("rd_timeout", 0, 1);
   endtask
   task summarize;
      if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      arst_n <= 1'b0;
      power_mode <= 2'h0;
      s_axi_awaddr <= 6'h00;
      s_axi_araddr <= 6'h00;
      s_axi_wdata <= 32'h0000_0000;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      cyc(5);
      arst_n <= 1'b1;
      cyc(3);
      rdc(sc, 8'h00);
      rdc(pe, 8'h00);
      rdc(es, 8'h00);
      rdc(ist, 8'h00);
      rdc(imsk, 8'h00);
      wr(sc, 8'hFF);
      rdc(sc, 8'h03);
      // Byte lane 0 strobe off: the write is answered but changes nothing
      wr(pe, 8'hFF, 2'h0, 4'hE);
      rdc(pe, 8'h00);
      wr(sc, 8'h00);
      wr(es, 8'hA5);
      rdc(es, 8'hA5);
      wr(pe, 8'hFF);
      rdc(pe, 8'hFF);
      wr(es, 8'h00);
      // Enabling pins already at a rising-polarity active level may flag
      wr(sc, 8'h04);
      rdc(sc, 8'h00);
      rdc(6'h14, 8'h00, 2'h2);
      wr(6'h14, 8'h00, 2'h2);
      wr(pe, 8'hF0);
      pm.set(4'h0);
      cyc(5);
      pm.set(4'hF);
      cyc(5);
      rdc(sc, 8'h00);
      wr(pe, 8'h01);
      pm.set(4'hE);
      cyc(5);
      rdc(sc, 8'h08);
      chk("irq", 0, key_irq);
      rdc(ist, 8'h01);
      chk("busirq", 0, bus_irq);
      wr(imsk, 8'h01);
      chk("busirq", 1, bus_irq);
      wr(sc, 8'h02);
      chk("irq", 1, key_irq);
      chk("wake", 1, core_wake);
      wr(sc, 8'h06);
      rdc(sc, 8'h02);
      pm.set(4'hC);
      cyc(5);
      rdc(sc, 8'h02);
      wr(ist, 8'h01);
      chk("busirq", 0, bus_irq);
      pm.set(4'hF);
      cyc(3);
      pm.set(4'hE);
      cyc(5);
      rdc(sc, 8'h0A);
      chk("busirq", 1, bus_irq);
      wr(sc, 8'h03);
      wr(sc, 8'h07);
      rdc(sc, 8'h0B);
      pm.set(4'hF);
      cyc(4);
      wr(sc, 8'h07);
      rdc(sc, 8'h03);
      wr(sc, 8'h02);
      wr(pe, 8'h00);
      pm.set(4'hE);
      wr(es, 8'h01);
      wr(pe, 8'h01);
      cyc(3);
      pm.set(4'hF);
      cyc(5);
      rdc(sc, 8'h0A);
      wr(sc, 8'h06);
      power_mode <= 2'h1;
      pm.set(4'hE);
      cyc(3);
      pm.set(4'hF);
      cyc(5);
      chk("irq", 1, key_irq);
      wr(sc, 8'h06);
      power_mode <= 2'h2;
      pm.set(4'hE);
      cyc(3);
      pm.set(4'hF);
      cyc(2);
      // Synchronised flag is still one edge away: wake came clockless
      chk("wake", 1, core_wake);
      chk("irq", 0, key_irq);
      power_mode <= 2'h3;
      cyc(3);
      chk("irq", 0, key_irq);
      power_mode <= 2'h0;
      cyc(3);
      rdc(pe, 8'h00);
      rdc(es, 8'h00);
      rdc(sc, 8'h00);
      summarize();
   end
   // Whole sequence needs well under two thousand cycles
   initial begin
      cyc(5000);
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
